/* File: hdl/lams_top.v */
// Purpose: mode control of a local interrupt controller, AXI4-Lite slave
// Assumes: inputs synchronous to clk_sys
// Notes:   unmapped or faulting accesses answer SLVERR
//
// Functional notes
// RQ1 - entry low dword masked match fails entry
// RQ2 - entry failure reloads host; exit failure aborts
// RQ3 - enable and extended bits encode the state
// RQ4 - writes toward invalid encoding fault, state kept
// RQ5 - reset leaves legacy mode enabled
// RQ6 - reset loads 32-bit id; low byte upper
// RQ7 - reset clears legacy fields, timers, self register
// RQ8 - vector-table entries cleared, masked; version kept
// RQ9 - spurious vector FFH, destination format ones
// RQ10 - legacy to extended keeps id, derives logical
// RQ11 - legacy may go disabled
// RQ12 - INIT in legacy keeps id, reinitialises rest
// RQ13 - hard reset always gives legacy, full init
// RQ14 - extended may only go disabled, id kept
// RQ15 - extended to legacy directly faults
// RQ16 - INIT in extended keeps mode, 32-bit id
// RQ17 - disabled only goes legacy; contents lost (cleared only on extended to disabled, kept from legacy)
// RQ18 - INIT while disabled stays disabled
// RQ19 - switch drops logical, written id, command high
// RQ20 - software enables remapping before extended mode
// RQ21 - window accesses fault unless extended mode
// RQ22 - mode bits change atomically
//
// The implementer's own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/10ps
`include "lams_defines.vh"
module lams_top (
   // clock and reset
   input  wire        clk_sys,
   input  wire        rst,
   // hardware identity and events
   input  wire [31:0] procIdStrap,
   input  wire        initReq,
   input  wire        reqSetValid,
   input  wire [7:0]  reqSetNum,
   // axi4-lite write address
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   input  wire [11:0] s_axi_awaddr,
   // axi4-lite write data
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   // axi4-lite write response
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   output reg  [1:0]  s_axi_bresp,
   // axi4-lite read address
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   input  wire [11:0] s_axi_araddr,
   // axi4-lite read data
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   // mode and event outputs
   output reg         modeEnable,
   output reg         modeExtended,
   output reg         gpFaultPulse,
   output wire        entryReloadPulse,
   output wire        exitAbortPulse
);
   // merge strobed bytes into an old word
   function [31:0] mergeStrb(input [31:0] old, input [31:0] nw, input [3:0] stb);
      integer b;
      begin
         mergeStrb = old;
         for (b = 0; b < 4; b = b + 1) begin
            if (stb[b]) mergeStrb[8*b +: 8] = nw[8*b +: 8];
         end
      end
   endfunction

   // vector-table word index, all ones if none
   function [2:0] lvtIdx(input [11:0] a);
      begin
         lvtIdx = 3'b111;
         if (a >= `LAMS_OFS_LVT0 && a < `LAMS_OFS_LVT0 + 12'd24 && a[1:0] == 2'b00) begin
            lvtIdx = a[4:2];
         end
      end
   endfunction

   // write channel holding registers
   reg  [11:0] wAddr_q;       // latched write address
   reg  [31:0] wData_q;       // latched write data
   reg  [3:0]  wStrb_q;       // latched byte strobes
   wire        doWr;          // both halves in, no answer pending
   wire [31:0] wMerged;       // strobes applied to zero

   // control and configuration state
   reg  [31:0] hwId_q;        // 32-bit identity caught from the strap
   reg         idLoad_q;      // strap capture pending
   reg  [7:0]  mmioId_q;      // legacy id of the memory port
   reg  [31:0] ldr_q;         // logical destination
   reg  [7:0]  tpr_q;         // task priority
   reg  [31:0] dcr_q;         // timer divide
   reg  [31:0] cmdLo_q;       // command low half
   reg  [31:0] cmdHi_q;       // command high half
   reg  [31:0] tInit_q;       // timer initial count
   reg  [31:0] tCur_q;        // timer current count
   reg  [31:0] svr_q;         // spurious vector
   reg  [31:0] dfr_q;         // destination format, legacy only
   reg  [7:0]  self_q;        // last self-interrupt vector
   reg  [31:0] lvt_q [0:5];   // local vector table
   reg  [31:0] vec_q [0:23];  // request, in-service and trigger-mode words
   reg  [2:0]  status_q;      // sticky gp / reload / abort

   // mode decision wires
   wire        fsmAccept;
   wire        fsmReject;
   wire        isDis;
   wire        isLeg;
   wire        isExt;
   wire        baseWr;        // write hits base control
   wire        toExt;         // accepted legacy to extended switch
   wire        extToDis;      // accepted extended to disabled switch
   wire        reinit;        // clear registers, vector table and vector words; identity, mode and status kept
   wire        probeFault;    // window access outside extended mode
   wire        entryWr;       // entry dword presented
   wire        exitWr;        // exit dword presented
   reg         wrMapped;      // write address decodes
   reg         wrFault;       // write answered with a fault
   reg  [31:0] rdData;        // read mux
   reg         rdMapped;      // read address decodes

   assign doWr     = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
   assign wMerged  = mergeStrb(32'h0000_0000, wData_q, wStrb_q);
   assign baseWr   = doWr && (wAddr_q == `LAMS_OFS_BASECTL);
   assign toExt    = fsmAccept & isLeg & wMerged[`LAMS_BIT_EXTENDED_MODE_BIT];
   assign extToDis = fsmAccept & isExt & ~wMerged[`LAMS_BIT_EN];
   // leaving extended loses all but identity and status [RQ17]
   assign reinit   = initReq | extToDis;
   assign entryWr  = doWr && (wAddr_q == `LAMS_OFS_ENTRY);
   assign exitWr   = doWr && (wAddr_q == `LAMS_OFS_EXIT);
   // register-interface window needs extended mode [RQ21]
   assign probeFault = doWr && (wAddr_q == `LAMS_OFS_PROBE) && ~isExt &&
                       (wMerged >= `LAMS_MR_LO) && (wMerged <= `LAMS_MR_HI);

   // state encoding lives in the mode tracker [RQ3]
   lams_mode_fsm u_mode (
      .clk_sys (clk_sys),
      .rst     (rst),
      .wrValid (baseWr),
      .wrBits  ({wMerged[`LAMS_BIT_EXTENDED_MODE_BIT], wMerged[`LAMS_BIT_EN]}),
      .accept  (fsmAccept),
      .reject  (fsmReject),
      .isDis   (isDis),
      .isLeg   (isLeg),
      .isExt   (isExt)
   );

   // transition-area entry screening
   lams_entry_check u_entry (
      .clk_sys       (clk_sys),
      .rst           (rst),
      .chkValid      (entryWr | exitWr),
      .chkIsExit     (exitWr),
      .entryLowDword (wMerged),
      .reloadHost    (entryReloadPulse),
      .abortExit     (exitAbortPulse)
   );

   // write decode: mapped offsets and faults
   always @* begin
      wrMapped = 1'b1;
      wrFault  = 1'b0;
      case (wAddr_q)
         `LAMS_OFS_BASECTL: wrFault = fsmReject;   // [RQ4] [RQ15]
         `LAMS_OFS_STATUS, `LAMS_OFS_ID, `LAMS_OFS_LDR, `LAMS_OFS_TPR,
         `LAMS_OFS_DCR, `LAMS_OFS_CMDLO, `LAMS_OFS_CMDHI, `LAMS_OFS_TINIT,
         `LAMS_OFS_SVR, `LAMS_OFS_DFR, `LAMS_OFS_SELF, `LAMS_OFS_ENTRY,
         `LAMS_OFS_EXIT: wrMapped = 1'b1;
         `LAMS_OFS_PROBE: wrFault = probeFault;
         default: wrMapped = (lvtIdx(wAddr_q) != 3'b111);
      endcase
   end

   // axi write: address and data in either order
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `LAMS_RESP_OKAY;
         wAddr_q       <= 12'h000;
         wData_q       <= 32'h0000_0000;
         wStrb_q       <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            wAddr_q       <= {s_axi_awaddr[11:2], 2'b00};
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wData_q      <= s_axi_wdata;
            wStrb_q      <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (doWr) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wrMapped && !wrFault) ? `LAMS_RESP_OKAY : `LAMS_RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // identity: strap caught at the first edge after reset
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         idLoad_q <= 1'b1;
         hwId_q   <= 32'h0000_0000;
         mmioId_q <= 8'h00;
      end else if (idLoad_q) begin
         idLoad_q <= 1'b0;
         hwId_q   <= procIdStrap;          // [RQ6] [RQ13]
         mmioId_q <= procIdStrap[7:0];     // [RQ6]
      end else if (toExt) begin
         mmioId_q <= hwId_q[7:0];          // memory-port id dropped [RQ19] [RQ14]
      end else if (doWr && isLeg && wAddr_q == `LAMS_OFS_ID && wStrb_q[3]) begin
         mmioId_q <= wData_q[31:24];       // INIT keeps this [RQ12] [RQ16]
      end
   end

   // register bank; INIT and reset load the same values
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ldr_q   <= 32'h0000_0000;         // [RQ7]
         tpr_q   <= 8'h00;
         dcr_q   <= 32'h0000_0000;
         cmdLo_q <= 32'h0000_0000;
         cmdHi_q <= 32'h0000_0000;
         tInit_q <= 32'h0000_0000;
         tCur_q  <= 32'h0000_0000;
         self_q  <= 8'h00;
         svr_q   <= `LAMS_RST_SVR;         // [RQ9]
         dfr_q   <= `LAMS_RST_DFR;         // [RQ9]
      end else if (reinit) begin
         ldr_q   <= 32'h0000_0000;         // [RQ12] [RQ16] [RQ17]
         tpr_q   <= 8'h00;
         dcr_q   <= 32'h0000_0000;
         cmdLo_q <= 32'h0000_0000;
         cmdHi_q <= 32'h0000_0000;
         tInit_q <= 32'h0000_0000;
         tCur_q  <= 32'h0000_0000;
         self_q  <= 8'h00;
         svr_q   <= `LAMS_RST_SVR;
         dfr_q   <= `LAMS_RST_DFR;
      end else if (toExt) begin
         // logical id: cluster and one-hot member [RQ10] [RQ19]
         ldr_q   <= {hwId_q[19:4], 16'h0001 << hwId_q[3:0]};
         cmdHi_q <= 32'h0000_0000;         // [RQ19]
      end else if (doWr && !isDis) begin
         case (wAddr_q)
            `LAMS_OFS_LDR:   if (isLeg) ldr_q <= mergeStrb(ldr_q, wData_q, wStrb_q);
            `LAMS_OFS_TPR:   tpr_q   <= wMerged[7:0];
            `LAMS_OFS_DCR:   dcr_q   <= wMerged & `LAMS_DCR_MASK;
            `LAMS_OFS_CMDLO: cmdLo_q <= mergeStrb(cmdLo_q, wData_q, wStrb_q);
            `LAMS_OFS_CMDHI: cmdHi_q <= mergeStrb(cmdHi_q, wData_q, wStrb_q);
            `LAMS_OFS_TINIT: begin
               tInit_q <= mergeStrb(tInit_q, wData_q, wStrb_q);
               tCur_q  <= mergeStrb(tInit_q, wData_q, wStrb_q);
            end
            `LAMS_OFS_SVR:   svr_q   <= mergeStrb(svr_q, wData_q, wStrb_q);
            // legacy-only registers ignore extended writes [RQ21]
            `LAMS_OFS_DFR:   if (isLeg) dfr_q <= mergeStrb(dfr_q, wData_q, wStrb_q);
            `LAMS_OFS_SELF:  if (isExt) self_q <= wMerged[7:0];
            default:         ;
         endcase
      end
   end

   // local vector table, one slot each
   genvar gi;
   generate
      for (gi = 0; gi < `LAMS_LVT_NUM; gi = gi + 1) begin : g_lvt
         always @(posedge clk_sys or posedge rst) begin
            if (rst) begin
               lvt_q[gi] <= `LAMS_RST_LVT;    // [RQ8]
            end else if (reinit) begin
               lvt_q[gi] <= `LAMS_RST_LVT;    // [RQ8]
            end else if (doWr && !isDis && lvtIdx(wAddr_q) == gi) begin
               lvt_q[gi] <= mergeStrb(lvt_q[gi], wData_q, wStrb_q);
            end
         end
      end
   endgenerate

   // request words collect arrivals; others stay clear
   generate
      for (gi = 0; gi < `LAMS_VEC_WORDS; gi = gi + 1) begin : g_vec
         always @(posedge clk_sys or posedge rst) begin
            if (rst) begin
               vec_q[gi] <= 32'h0000_0000;    // [RQ7]
            end else if (reinit) begin
               vec_q[gi] <= 32'h0000_0000;
            end else if (gi < 8 && reqSetValid && !isDis && reqSetNum[7:5] == gi) begin
               vec_q[gi] <= vec_q[gi] | (32'h0000_0001 << reqSetNum[4:0]);
            end
         end
      end
   endgenerate

   // sticky status: a new event beats a clear in the same cycle
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         status_q     <= 3'b000;
         gpFaultPulse <= 1'b0;
      end else begin
         gpFaultPulse <= doWr & wrFault;
         status_q <= (status_q & ~((doWr && wAddr_q == `LAMS_OFS_STATUS) ? wMerged[2:0] : 3'b000))
                     | {exitAbortPulse, entryReloadPulse, doWr & wrFault};
      end
   end

   // mode bits mirrored to the pins
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         modeEnable   <= 1'b1;            // [RQ5]
         modeExtended <= 1'b0;
      end else begin
         modeEnable   <= (baseWr & fsmAccept) ? wMerged[`LAMS_BIT_EN] : ~isDis;
         modeExtended <= (baseWr & fsmAccept) ? wMerged[`LAMS_BIT_EXTENDED_MODE_BIT] : isExt;
      end
   end

   // read mux
   always @* begin
      rdMapped = 1'b1;
      rdData   = 32'h0000_0000;
      case (s_axi_araddr & 12'hFFC)
         `LAMS_OFS_BASECTL: rdData = {30'h0, isExt, ~isDis};
         `LAMS_OFS_STATUS:  rdData = {29'h0, status_q};
         // legacy: byte id on top; extended: full identity
         `LAMS_OFS_ID:      rdData = isExt ? hwId_q : {mmioId_q, 24'h00_0000};
         `LAMS_OFS_LDR:     rdData = ldr_q;
         `LAMS_OFS_TPR:     rdData = {24'h00_0000, tpr_q};
         `LAMS_OFS_DCR:     rdData = dcr_q;
         `LAMS_OFS_CMDLO:   rdData = cmdLo_q;
         `LAMS_OFS_CMDHI:   rdData = cmdHi_q;
         `LAMS_OFS_TINIT:   rdData = tInit_q;
         `LAMS_OFS_TCUR:    rdData = tCur_q;
         `LAMS_OFS_SVR:     rdData = svr_q;
         `LAMS_OFS_DFR:     rdData = isExt ? 32'h0000_0000 : dfr_q;
         `LAMS_OFS_VER:     rdData = `LAMS_VERSION;   // untouched by reset [RQ8]
         default: begin
            if (lvtIdx(s_axi_araddr & 12'hFFC) != 3'b111) begin
               rdData = lvt_q[lvtIdx(s_axi_araddr & 12'hFFC)];
            end else if (s_axi_araddr >= `LAMS_OFS_VEC0 &&
                         s_axi_araddr < `LAMS_OFS_VEC0 + 12'd96) begin
               rdData = vec_q[s_axi_araddr[6:2]];
            end else begin
               rdMapped = 1'b0;
            end
         end
      endcase
   end

   // axi read: answer registered on the same edge as the take
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= `LAMS_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= rdData;
         s_axi_rresp   <= rdMapped ? `LAMS_RESP_OKAY : `LAMS_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end
endmodule // lams_top

/* File: shared/lams_defines.vh */
// Purpose: mode block constants
// Assumes: 32-bit register words
// Notes:   offsets are byte addresses
`ifndef LAMS_DEFINES_VH
`define LAMS_DEFINES_VH

// register offsets
`define LAMS_OFS_BASECTL  12'h000
`define LAMS_OFS_STATUS   12'h004
`define LAMS_OFS_ID       12'h008
`define LAMS_OFS_LDR      12'h00C
`define LAMS_OFS_TPR      12'h010
`define LAMS_OFS_DCR      12'h014
`define LAMS_OFS_CMDLO    12'h018
`define LAMS_OFS_CMDHI    12'h01C
`define LAMS_OFS_TINIT    12'h020
`define LAMS_OFS_TCUR     12'h024
`define LAMS_OFS_SVR      12'h028
`define LAMS_OFS_DFR      12'h02C
`define LAMS_OFS_SELF     12'h030
`define LAMS_OFS_VER      12'h034
`define LAMS_OFS_LVT0     12'h040
`define LAMS_OFS_ENTRY    12'h060
`define LAMS_OFS_EXIT     12'h064
`define LAMS_OFS_PROBE    12'h068
`define LAMS_OFS_VEC0     12'h100

// field positions
`define LAMS_BIT_EN       0
`define LAMS_BIT_EXTENDED_MODE_BIT     1
`define LAMS_BIT_LVTMASK  16
`define LAMS_ST_GP        0
`define LAMS_ST_RELOAD    1
`define LAMS_ST_ABORT     2

// reset values and masks
`define LAMS_RST_LVT      32'h0001_0000
`define LAMS_RST_SVR      32'h0000_00FF
`define LAMS_RST_DFR      32'hFFFF_FFFF
`define LAMS_DCR_MASK     32'h0000_000B
`define LAMS_VERSION      32'h0000_0010
`define LAMS_LVT_NUM      6
`define LAMS_VEC_WORDS    24

// register-interface window and entry-area check
`define LAMS_MR_LO        32'h0000_0800
`define LAMS_MR_HI        32'h0000_0BFF
`define LAMS_ENTRY_MASK   32'hFFFF_F800
`define LAMS_ENTRY_MATCH  32'h0000_0800

// bus responses
`define LAMS_RESP_OKAY    2'b00
`define LAMS_RESP_SLVERR  2'b10
`endif

/* File: hdl/lams_mode_fsm.v */
// Purpose: three-state mode tracker
// Assumes: wrValid is a one-cycle request, wrBits = {extended_mode_bit, en}
// Notes:   accept and reject are combinational
`timescale 1ns/10ps
module lams_mode_fsm (
   // clock and reset
   input  wire       clk_sys,
   input  wire       rst,
   // base-control write request
   input  wire       wrValid,
   input  wire [1:0] wrBits,
   // decision
   output reg        accept,
   output reg        reject,
   // present state, one-hot
   output wire       isDis,
   output wire       isLeg,
   output wire       isExt
);
   localparam [2:0] ST_DIS = 3'b001;   // both bits clear
   localparam [2:0] ST_LEG = 3'b010;   // enable only
   localparam [2:0] ST_EXT = 3'b100;   // enable and extended

   reg [2:0] state_q;   // current mode
   reg [2:0] state_d;   // next mode

   assign isDis = state_q[0];
   assign isLeg = state_q[1];
   assign isExt = state_q[2];

   // decode the target of a write and its legality
   always @* begin
      state_d = state_q;
      accept  = 1'b0;
      reject  = 1'b0;
      if (wrValid) begin
         case (state_q)
            ST_DIS: begin
               // only the legacy target leaves disabled [RQ17]
               if (wrBits == 2'b01) begin
                  state_d = ST_LEG;
                  accept  = 1'b1;
               end else if (wrBits == 2'b00) begin
                  accept = 1'b1;
               end else begin
                  reject = 1'b1;     // invalid encoding or direct jump [RQ4]
               end
            end
            ST_LEG: begin
               if (wrBits == 2'b11) begin
                  state_d = ST_EXT;  // [RQ10]
                  accept  = 1'b1;
               end else if (wrBits == 2'b00) begin
                  state_d = ST_DIS;  // [RQ11]
                  accept  = 1'b1;
               end else if (wrBits == 2'b01) begin
                  accept = 1'b1;
               end else begin
                  reject = 1'b1;     // [RQ4]
               end
            end
            ST_EXT: begin
               if (wrBits == 2'b00) begin
                  state_d = ST_DIS;  // [RQ14]
                  accept  = 1'b1;
               end else if (wrBits == 2'b11) begin
                  accept = 1'b1;
               end else begin
                  reject = 1'b1;     // to legacy or invalid [RQ15] [RQ4]
               end
            end
            default: begin
               state_d = ST_LEG;
               reject  = 1'b1;
            end
         endcase
      end
   end

   // both mode bits move together in one edge [RQ22]
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_q <= ST_LEG;           // leave reset in legacy mode [RQ5] [RQ13]
      end else begin
         state_q <= state_d;          // INIT never touches the mode [RQ12] [RQ16] [RQ18]
      end
   end
endmodule // lams_mode_fsm

/* File: hdl/lams_entry_check.v */
// Purpose: screens transition-area entries
// Assumes: chkValid is a one-cycle pulse
// Notes:   results are registered one-cycle pulses
`timescale 1ns/10ps
`include "lams_defines.vh"
module lams_entry_check (
   // clock and reset
   input  wire        clk_sys,
   input  wire        rst,
   // entry under test
   input  wire        chkValid,
   input  wire        chkIsExit,
   input  wire [31:0] entryLowDword,
   // outcome pulses
   output reg         reloadHost,
   output reg         abortExit
);
   wire hit;   // entry falls inside the controller range
   assign hit = ((entryLowDword & `LAMS_ENTRY_MASK) == `LAMS_ENTRY_MATCH); // [RQ1]

   // entry failure reloads host state, exit failure aborts
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         reloadHost <= 1'b0;
         abortExit  <= 1'b0;
      end else begin
         reloadHost <= chkValid & hit & ~chkIsExit; // [RQ2]
         abortExit  <= chkValid & hit & chkIsExit;  // [RQ2]
      end
   end
endmodule // lams_entry_check

/* File: sim/lams_mode_monitor.sv */
// Purpose: mode block assertions
// Assumes: bready held high
// Notes:   m is {enable, extended}
`timescale 1ns/10ps
module lams_mode_monitor (
   input wire       clk_sys,
   input wire       rst,
   input wire       s_axi_bvalid,
   input wire [1:0] s_axi_bresp,
   input wire       modeEnable,
   input wire       modeExtended,
   input wire       gpFaultPulse,
   input wire       entryReloadPulse,
   input wire       exitAbortPulse
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   // current encoding
   wire [1:0] m = {modeEnable, modeExtended};
   no_invalid_a: assert property (m != 2'b01) else $error("invalid mode");
   rst_legacy_a: assert property ($fell(rst) |-> m == 2'b10) else $error("not legacy");
   ext_leave_a: assert property (m == 2'b11 |=> m[0] == m[1]) else $error("ext exit");
   dis_leave_a: assert property (m == 2'b00 |=> !m[0]) else $error("dis exit");
   fault_keep_a: assert property (gpFaultPulse |-> m == $past(m, 2)) else $error("moved");
   fault_resp_a: assert property (gpFaultPulse |-> ##[0:1] (s_axi_bvalid && s_axi_bresp == 2'b10))
      else $error("fault not answered");
   entry_once_a: assert property (entryReloadPulse |=> !entryReloadPulse && !exitAbortPulse)
      else $error("entry pulse");
   exit_once_a: assert property (exitAbortPulse |-> !entryReloadPulse ##1 !exitAbortPulse)
      else $error("exit pulse");
   cover property (m == 2'b11);
   cover property (gpFaultPulse);
   cover property (entryReloadPulse);
endmodule // lams_mode_monitor

/* File: sim/lams_core_model.sv */
// Purpose: core model issuing register accesses
// Assumes: one access at a time
// Notes:   released lines show inverted values
`timescale 1ns/10ps
module lams_core_model (
   input  wire        clk_sys,
   output reg         s_axi_awvalid = 0,
   output reg  [11:0] s_axi_awaddr = 0,
   output reg         s_axi_wvalid = 0,
   output reg  [31:0] s_axi_wdata = 0,
   output wire [3:0]  s_axi_wstrb,
   output wire        s_axi_bready,
   output reg         s_axi_arvalid = 0,
   output reg  [11:0] s_axi_araddr = 0,
   output wire        s_axi_rready,
   input  wire        s_axi_awready,
   input  wire        s_axi_wready,
   input  wire        s_axi_bvalid,
   input  wire        s_axi_arready,
   input  wire        s_axi_rvalid
);
   assign s_axi_wstrb = 4'hF;
   assign s_axi_bready = 1'b1;
   assign s_axi_rready = 1'b1;
   // address and data go out together, each dropped when taken
   task wr(input [11:0] a, input [31:0] d);
      begin
         {s_axi_awvalid, s_axi_wvalid, s_axi_awaddr, s_axi_wdata} <= {2'b11, a, d};
         do begin
            @(posedge clk_sys);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
         end while ((s_axi_awvalid & !s_axi_awready) | (s_axi_wvalid & !s_axi_wready));
         {s_axi_awaddr, s_axi_wdata} <= ~{a, d};
         do @(posedge clk_sys); while (!s_axi_bvalid);
      end
   endtask
   task rd(input [11:0] a);
      begin
         {s_axi_arvalid, s_axi_araddr} <= {1'b1, a};
         do @(posedge clk_sys); while (!s_axi_arready);
         {s_axi_arvalid, s_axi_araddr} <= {1'b0, ~a};
         do @(posedge clk_sys); while (!s_axi_rvalid);
      end
   endtask
endmodule // lams_core_model

/* File: sim/testbench.sv */
// Purpose: mode block bench
// Assumes: one bus master
// Notes:   answers compared in order
`timescale 1ns/10ps
`include "lams_defines.vh"
module testbench;
   localparam [1:0] OK = `LAMS_RESP_OKAY, SE = `LAMS_RESP_SLVERR;
   localparam [11:0] BC = `LAMS_OFS_BASECTL, ID = `LAMS_OFS_ID, TP = `LAMS_OFS_TPR;
   reg         clk_sys = 0, rst = 1, initReq = 0, reqSetValid = 0;
   reg  [7:0]  reqSetNum = 8'h25;  // vector 37 sits in word 1, bit 5
   reg  [31:0] procIdStrap = 0, d;
   reg  [1:0]  cur = 2'b10; // expected {enable, extended}
   reg  [33:0] expQ[$]; // expected {resp, data}
   integer     nFail = 0, checks = 0, cyc = 0, nEnt = 0, nExt = 0, nGp = 0;
   wire s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   wire s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, gpFaultPulse;
   wire modeEnable, modeExtended, entryReloadPulse, exitAbortPulse;
   wire [11:0] s_axi_awaddr, s_axi_araddr;
   wire [31:0] s_axi_wdata, s_axi_rdata;
   wire [3:0]  s_axi_wstrb;
   wire [1:0]  s_axi_bresp, s_axi_rresp;
   lams_top u_dut (.*);
   lams_core_model u_core (.*);
   always #2.5 clk_sys = ~clk_sys;
   function [31:0] lfsr(input [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task chk(input [33:0] got, input [33:0] exp);
      begin
         checks = checks + 1;
         if (got !== exp) begin
            nFail = nFail + 1;
            $display("unexpected at %0t: saw %h wanted %h", $time, got, exp);
         end
      end
   endtask
   // note the answer, then access
   task acc(input rdn, input [11:0] a, input [31:0] v, input [1:0] s);
      begin
         expQ.push_back({s, rdn ? v : 32'h0});
         if (rdn) u_core.rd(a);
         else u_core.wr(a, v);
      end
   endtask
   task md;
      chk({modeEnable, modeExtended}, cur);
   endtask
   // base-control write, mode moves if accepted
   task bw(input [1:0] m, input [1:0] s);
      begin
         acc(0, BC, {30'h0, m[0], m[1]}, s);
         if (s == OK) cur = m;
         md;
      end
   endtask
   task pulse(input [2:0] k); // one-hot {rst, initReq, reqSetValid}
      begin
         {rst, initReq, reqSetValid} <= k;
         @(posedge clk_sys);
         {rst, initReq, reqSetValid} <= 3'b000;
         @(posedge clk_sys);
      end
   endtask
   task stop_test;
      begin
         $display("mismatches %0d in %0d checks", nFail, checks);
         if (nFail == 0 && checks > 0) $display("[ PASS ]");
         else $display("[ FAIL ]");
         $finish;
      end
   endtask
   // answer watcher, pulse counters and hang guard
   always @(posedge clk_sys) begin
      if (s_axi_bvalid) chk({s_axi_bresp, 32'h0}, expQ.pop_front());
      if (s_axi_rvalid) chk({s_axi_rresp, s_axi_rdata}, expQ.pop_front());
      nEnt <= nEnt + entryReloadPulse;
      nExt <= nExt + exitAbortPulse;
      nGp <= nGp + gpFaultPulse;
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         nFail = nFail + 1;
         stop_test;
      end
   end
   initial begin
      procIdStrap <= lfsr(32'h0000_023c);
      repeat (4) @(posedge clk_sys);
      rst <= 0;
      repeat (2) @(posedge clk_sys);
      md;
      acc(1, ID, {procIdStrap[7:0], 24'h0}, OK);
      acc(1, `LAMS_OFS_SVR, 32'hFF, OK);
      acc(1, `LAMS_OFS_DFR, 32'hFFFF_FFFF, OK);
      acc(1, `LAMS_OFS_LVT0 + 12'h14, 32'h1_0000, OK);
      acc(1, `LAMS_OFS_VER, 32'h10, OK);
      acc(1, 12'h0F0, 0, SE);
      acc(0, `LAMS_OFS_PROBE, 32'hBFF, SE);
      bw(2'b01, SE);
      acc(0, TP, 32'h5A, OK);
      pulse(3'b001);
      acc(1, 12'h104, 32'h20, OK);
      pulse(3'b010);
      acc(1, 12'h104, 0, OK);
      acc(1, TP, 0, OK);
      acc(1, ID, {procIdStrap[7:0], 24'h0}, OK);
      d = 32'h800 | lfsr(procIdStrap) & 32'h7FF;
      acc(0, `LAMS_OFS_ENTRY, d, OK);
      acc(0, `LAMS_OFS_EXIT, d, OK);
      acc(0, `LAMS_OFS_ENTRY, d ^ 32'h1800, OK);
      repeat (2) @(posedge clk_sys);
      chk({nEnt, nExt[1:0]}, {32'd1, 2'd1});
      bw(2'b00, OK);
      bw(2'b10, OK);
      acc(0, TP, 32'h5A, OK);
      acc(0, `LAMS_OFS_CMDHI, 32'hA500_0000, OK);
      bw(2'b11, OK); // remapping taken as already on
      acc(1, ID, procIdStrap, OK);
      acc(1, `LAMS_OFS_LDR, {procIdStrap[19:4], 16'h1 << procIdStrap[3:0]}, OK);
      acc(1, TP, 32'h5A, OK);
      acc(1, `LAMS_OFS_CMDHI, 0, OK);
      acc(0, `LAMS_OFS_PROBE, 32'h800, OK);
      bw(2'b10, SE);
      bw(2'b01, SE);
      pulse(3'b010);
      md;
      acc(1, ID, procIdStrap, OK);
      bw(2'b00, OK);
      bw(2'b11, SE);
      pulse(3'b010);
      md;
      bw(2'b10, OK);
      acc(1, ID, {procIdStrap[7:0], 24'h0}, OK);
      bw(2'b11, OK);
      chk(nGp, 5);
      pulse(3'b100);
      cur = 2'b10;
      md;
      stop_test;
   end
endmodule // testbench
bind lams_top lams_mode_monitor u_mon (.*);
